// ---- src/ch7r_offset_apply.sv ----
// Offset correction of channel 7 conversion results
`timescale 1ns/100ps
`default_nettype none
module ch7r_offset_apply
  import ch7r_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [23:0] sample_in,
  input  wire logic        sample_valid,
  input  wire logic [23:0] offset_value,
  output var  logic [23:0] corrected_data,
  output var  logic        corrected_valid
);

  // Offset result register
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      corrected_data  <= 24'h000000;
      corrected_valid <= 1'b0;
    end
    else
    begin
      corrected_valid <= sample_valid;
      if (sample_valid)
      begin
        corrected_data <= ch7r_sat_add(sample_in, offset_value);
      end
    end
  end

endmodule
`default_nettype wire

// ---- src/ch7r_pkg.sv ----
// Constants, types and helpers for the channel 7 register block
package ch7r_pkg;

  localparam int          CH7R_REG_W       = 16;
  localparam int          CH7R_DATA_W      = 24;
  localparam int          CH7R_BUS_W       = 32;
  localparam int          CH7R_IDX_W       = 8;
  localparam int          CH7R_IDX_LSB     = 2;

  // Register indexes; byte address is four times the index
  localparam logic [7:0]  CH7R_IDX_CFG       = 8'h2c;
  localparam logic [7:0]  CH7R_IDX_OCAL_HIGH = 8'h2d;
  localparam logic [7:0]  CH7R_IDX_OCAL_LOW  = 8'h2e;

  // Reset values
  localparam logic [15:0] CH7R_RST_CFG       = 16'h0000;
  localparam logic [15:0] CH7R_RST_OCAL_HIGH = 16'h0000;
  localparam logic [15:0] CH7R_RST_OCAL_LOW  = 16'h0000;

  // Field positions
  localparam int          CH7R_PHASE_MSB   = 15;
  localparam int          CH7R_PHASE_LSB   = 6;
  localparam int          CH7R_DCOFF_BIT   = 2;
  localparam int          CH7R_SEL_MSB     = 1;
  localparam int          CH7R_SEL_LSB     = 0;
  localparam int          CH7R_LOWF_MSB    = 15;
  localparam int          CH7R_LOWF_LSB    = 8;

  // Writable bits; reserved bits stay zero
  localparam logic [15:0] CH7R_CFG_WMASK   = 16'hffc7;
  localparam logic [15:0] CH7R_LOW_WMASK   = 16'hff00;

  localparam logic [1:0]  CH7R_HTRANS_NONSEQ = 2'h2;
  localparam logic        CH7R_HRESP_OKAY    = 1'h0;
  localparam logic [3:0]  CH7R_GLOBAL_DC_OFF = 4'h0;

  typedef enum logic [1:0]
  {
    CH7R_SEL_PINS     = 2'h0,
    CH7R_SEL_SHORTED  = 2'h1,
    CH7R_SEL_TEST_POS = 2'h2,
    CH7R_SEL_TEST_NEG = 2'h3
  } ch7r_sel_e;

  // Word index of a byte address
  function automatic logic [7:0] ch7r_index(input logic [31:0] addr);
  begin
    return addr[CH7R_IDX_LSB +: CH7R_IDX_W];
  end
  endfunction

  // Signed add clipped to the 24-bit range
  function automatic logic [23:0] ch7r_sat_add(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] s;
  begin
    s = {a[23], a} + {b[23], b};
    if (s[24] != s[23])
    begin
      return s[24] ? 24'h800000 : 24'h7fffff;
    end
    return s[23:0];
  end
  endfunction

endpackage

// ---- src/ch7r_regs.sv ----
// Channel 7 configuration and offset registers on AHB-Lite
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ch7r_regs
  import ch7r_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic [3:0]  global_dc_filter_setting,
  input  wire logic [23:0] sample_in,
  input  wire logic        sample_valid,
  output var  logic [9:0]  chan7_phase_delay,
  output var  logic        chan7_dc_filter_off,
  output var  logic        chan7_dc_filter_active,
  output var  logic [1:0]  chan7_input_select,
  output var  logic [3:0]  chan7_route,
  output var  logic [23:0] chan7_offset_value,
  output var  logic [23:0] corrected_data,
  output var  logic        corrected_valid
);

  logic        ap_valid_reg;
  logic        ap_write_reg;
  logic [7:0]  ap_idx_reg;
  logic [15:0] cfg_reg;
  logic [15:0] ocal_high_reg;
  logic [15:0] ocal_low_reg;
  logic [15:0] cfg_next;
  logic [15:0] ocal_high_next;
  logic [15:0] ocal_low_next;
  logic        addr_phase_rd;
  logic [7:0]  addr_idx;
  logic [31:0] rdata_next;
  logic        rd_low_reg;

  assign addr_phase_rd = hready && hsel && (htrans == CH7R_HTRANS_NONSEQ) && !hwrite;
  assign addr_idx      = ch7r_index(haddr);

  // Address phase capture
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_idx_reg   <= 8'h00;
    end
    else if (hready)
    begin
      ap_valid_reg <= hsel && (htrans == CH7R_HTRANS_NONSEQ);
      ap_write_reg <= hwrite;
      ap_idx_reg   <= addr_idx;
    end
  end

  // Data phase write decode
  always_comb
  begin
    cfg_next       = cfg_reg;
    ocal_high_next = ocal_high_reg;
    ocal_low_next  = ocal_low_reg;
    if (ap_valid_reg && ap_write_reg)
    begin
      if (ap_idx_reg == CH7R_IDX_CFG)
      begin
        cfg_next = hwdata[15:0] & CH7R_CFG_WMASK;
      end
      else if (ap_idx_reg == CH7R_IDX_OCAL_HIGH)
      begin
        ocal_high_next = hwdata[15:0];
      end
      else if (ap_idx_reg == CH7R_IDX_OCAL_LOW)
      begin
        ocal_low_next = hwdata[15:0] & CH7R_LOW_WMASK;
      end
    end
  end

  // Register storage
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cfg_reg       <= CH7R_RST_CFG;
      ocal_high_reg <= CH7R_RST_OCAL_HIGH;
      ocal_low_reg  <= CH7R_RST_OCAL_LOW;
    end
    else
    begin
      cfg_reg       <= cfg_next;
      ocal_high_reg <= ocal_high_next;
      ocal_low_reg  <= ocal_low_next;
    end
  end

  // Read mux uses next values so a read after a write sees it
  always_comb
  begin
    rdata_next = 32'h00000000;
    if (addr_idx == CH7R_IDX_CFG)
    begin
      rdata_next = {16'h0000, cfg_next};
    end
    else if (addr_idx == CH7R_IDX_OCAL_HIGH)
    begin
      rdata_next = {16'h0000, ocal_high_next};
    end
    else if (addr_idx == CH7R_IDX_OCAL_LOW)
    begin
      rdata_next = {16'h0000, ocal_low_next};
    end
  end

  // Bus answer, no wait states
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= CH7R_HRESP_OKAY;
      rd_low_reg <= 1'b0;
    end
    else
    begin
      hreadyout  <= 1'b1;
      hresp      <= CH7R_HRESP_OKAY;
      rd_low_reg <= addr_phase_rd && (addr_idx == CH7R_IDX_OCAL_LOW);
      if (addr_phase_rd)
      begin
        hrdata <= rdata_next;
      end
    end
  end

  // Configuration outputs
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      chan7_phase_delay      <= CH7R_RST_CFG[CH7R_PHASE_MSB:CH7R_PHASE_LSB];
      chan7_dc_filter_off    <= CH7R_RST_CFG[CH7R_DCOFF_BIT];
      chan7_input_select     <= CH7R_RST_CFG[CH7R_SEL_MSB:CH7R_SEL_LSB];
      chan7_dc_filter_active <= 1'b0;
      chan7_route            <= 4'h1;
      chan7_offset_value     <= 24'h000000;
    end
    else
    begin
      chan7_phase_delay      <= cfg_next[CH7R_PHASE_MSB:CH7R_PHASE_LSB];
      chan7_dc_filter_off    <= cfg_next[CH7R_DCOFF_BIT];
      chan7_dc_filter_active <= !cfg_next[CH7R_DCOFF_BIT]
                                && (global_dc_filter_setting != CH7R_GLOBAL_DC_OFF);
      chan7_input_select     <= cfg_next[CH7R_SEL_MSB:CH7R_SEL_LSB];
      chan7_route            <= 4'h1 << cfg_next[CH7R_SEL_MSB:CH7R_SEL_LSB];
      chan7_offset_value[23:8] <= ocal_high_next;
      chan7_offset_value[7:0]  <= ocal_low_next[CH7R_LOWF_MSB:CH7R_LOWF_LSB];
    end
  end

  ch7r_offset_apply u_offset
  (
    .mclk            (mclk),
    .reset           (reset),
    .sample_in       (sample_in),
    .sample_valid    (sample_valid),
    .offset_value    (chan7_offset_value),
    .corrected_data  (corrected_data),
    .corrected_valid (corrected_valid)
  );

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic        wr_cfg;
  logic        wr_high;
  logic        wr_low;
  logic [9:0]  w_phase;
  logic [15:0] w_high;
  logic [7:0]  w_low;

  assign wr_cfg  = ap_valid_reg && ap_write_reg && (ap_idx_reg == CH7R_IDX_CFG);
  assign wr_high = ap_valid_reg && ap_write_reg && (ap_idx_reg == CH7R_IDX_OCAL_HIGH);
  assign wr_low  = ap_valid_reg && ap_write_reg && (ap_idx_reg == CH7R_IDX_OCAL_LOW);
  assign w_phase = hwdata[15:6];
  assign w_high  = hwdata[15:0];
  assign w_low   = hwdata[15:8];

  property p_phase;
    wr_cfg |=> (chan7_phase_delay == $past(w_phase));
  endproperty
  a_phase: assert property (p_phase) else $error("phase delay not taken from write");

  property p_dcoff;
    chan7_dc_filter_off |-> !chan7_dc_filter_active;
  endproperty
  a_dcoff: assert property (p_dcoff) else $error("filter active while disabled");

  property p_route;
    ##1 (chan7_route == (4'h1 << chan7_input_select));
  endproperty
  a_route: assert property (p_route) else $error("input routing mismatch");

  property p_high;
    wr_high |=> (chan7_offset_value[23:8] == $past(w_high));
  endproperty
  a_high: assert property (p_high) else $error("upper offset not applied");

  property p_high_rd;
    (addr_phase_rd && (addr_idx == CH7R_IDX_OCAL_HIGH) && !wr_high)
      |=> (hrdata == {8'h00, chan7_offset_value[23:8], 8'h00} >> 8);
  endproperty
  a_high_rd: assert property (p_high_rd) else $error("upper offset read wrong");

  property p_low;
    wr_low |=> (chan7_offset_value[7:0] == $past(w_low));
  endproperty
  a_low: assert property (p_low) else $error("lower offset not applied");

  property p_low_rsv;
    rd_low_reg |-> (hrdata[7:0] == 8'h00) && (hrdata[31:16] == 16'h0000);
  endproperty
  a_low_rsv: assert property (p_low_rsv) else $error("reserved byte not zero");

  property p_reset_cfg;
    $fell(reset) |-> (chan7_phase_delay == 10'h000) && (chan7_input_select == 2'h0)
                     && !chan7_dc_filter_off && (chan7_offset_value == 24'h000000);
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("reset values wrong");

  property p_apply;
    sample_valid |=> corrected_valid
                     && (corrected_data == ch7r_sat_add($past(sample_in), $past(chan7_offset_value)));
  endproperty
  a_apply: assert property (p_apply) else $error("offset not applied to sample");

  property p_ready;
    hreadyout && (hresp == CH7R_HRESP_OKAY);
  endproperty
  a_ready: assert property (p_ready) else $error("bus not ready or not okay");

endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the channel 7 register block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ch7r_pkg::*;
();
  localparam logic [31:0] A_CFG  = {22'h0, CH7R_IDX_CFG, 2'h0};
  localparam logic [31:0] A_HIGH = {22'h0, CH7R_IDX_OCAL_HIGH, 2'h0};
  localparam logic [31:0] A_LOW  = {22'h0, CH7R_IDX_OCAL_LOW, 2'h0};
  localparam logic [31:0] A_NONE = 32'h000000bc;

  logic        mclk;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [3:0]  global_dc_filter_setting;
  logic [23:0] sample_in;
  logic        sample_valid;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [9:0]  chan7_phase_delay;
  logic        chan7_dc_filter_off;
  logic        chan7_dc_filter_active;
  logic [1:0]  chan7_input_select;
  logic [3:0]  chan7_route;
  logic [23:0] chan7_offset_value;
  logic [23:0] corrected_data;
  logic        corrected_valid;
  int          miscompares;
  int          checked;
  logic [9:0]  ph [4];

  ch7r_regs DUT (
    .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .global_dc_filter_setting(global_dc_filter_setting), .sample_in(sample_in),
    .sample_valid(sample_valid), .chan7_phase_delay(chan7_phase_delay),
    .chan7_dc_filter_off(chan7_dc_filter_off),
    .chan7_dc_filter_active(chan7_dc_filter_active),
    .chan7_input_select(chan7_input_select), .chan7_route(chan7_route),
    .chan7_offset_value(chan7_offset_value), .corrected_data(corrected_data),
    .corrected_valid(corrected_valid)
  );

  always #2.5 mclk = ~mclk;

  task automatic final_report();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= CH7R_HTRANS_NONSEQ;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~d;
    wait_ready();
    r = hrdata;
    check(32'(hresp), 32'(CH7R_HRESP_OKAY));
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask

  task automatic settle();
    @(posedge mclk);
  endtask

  // One sample in, corrected result and one-cycle valid out
  task automatic sample_chk(input logic [23:0] s, input logic [23:0] exp);
    int n;
    @(posedge mclk);
    sample_in    <= s;
    sample_valid <= 1'b1;
    @(posedge mclk);
    sample_valid <= 1'b0;
    sample_in    <= ~s;
    n = 0;
    while (corrected_valid !== 1'b1 && n < 8)
    begin
      @(posedge mclk);
      n++;
    end
    if (corrected_valid !== 1'b1)
    begin
      miscompares++;
      final_report();
    end
    check(32'(corrected_data), 32'(exp));
    @(posedge mclk);
    check(32'(corrected_valid), 32'h0);
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    final_report();
  end

  initial
  begin
    mclk = 0; reset = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; global_dc_filter_setting = 4'h0;
    sample_in = 0; sample_valid = 0;
    ph = '{10'h200, 10'h1ff, 10'h001, 10'h3ff};
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rd_chk(A_CFG, 32'h0);
    rd_chk(A_HIGH, 32'h0);
    rd_chk(A_LOW, 32'h0);
    check(32'(chan7_route), 32'h1);
    wr(A_CFG, 32'hffffffff);
    rd_chk(A_CFG, 32'h0000ffc7);
    for (int i = 0; i < 4; i++)
    begin
      global_dc_filter_setting <= (i < 2) ? CH7R_GLOBAL_DC_OFF : 4'h9;
      wr(A_CFG, {16'h0, ph[i], 3'h0, i[0], i[1:0]});
      settle();
      check(32'(chan7_phase_delay), 32'(ph[i]));
      check(32'(chan7_dc_filter_off), 32'(i[0]));
      check(32'(chan7_dc_filter_active), 32'(i == 2));
      check(32'(chan7_input_select), 32'(i));
      check(32'(chan7_route), 32'h1 << i);
    end
    wr(A_HIGH, 32'habcd1234);
    rd_chk(A_HIGH, 32'h00001234);
    wr(A_LOW, 32'h000056ff);
    rd_chk(A_LOW, 32'h00005600);
    settle();
    check(32'(chan7_offset_value), 32'h123456);
    sample_chk(24'h000010, 24'h123466);
    sample_chk(24'hfffff0, 24'h123446);
    wr(A_HIGH, 32'h0000ffff);
    wr(A_LOW, 32'h0000ff00);
    settle();
    sample_chk(24'h000005, 24'h000004);
    sample_chk(24'h800000, 24'h800000);
    wr(A_NONE, 32'h00000000);
    rd_chk(A_NONE, 32'h0);
    rd_chk(A_CFG, {16'h0, ph[3], 6'h07});
    rd_chk(A_HIGH, 32'h0000ffff);
    rd_chk(A_LOW, 32'h0000ff00);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd_chk(A_CFG, 32'h0);
    rd_chk(A_HIGH, 32'h0);
    rd_chk(A_LOW, 32'h0);
    check(32'(chan7_route), 32'h1);
    check(32'(chan7_phase_delay), 32'h0);
    check(32'(chan7_offset_value), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
